// >>> hdl/csa_accum.sv
// csa_accum: sums conversions and emits the sum divided by the count.
// assumes: conversion valid pulses from the same clock domain.
`timescale 1ns/1ps
module csa_accum (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // configuration
  input  wire logic [2:0]              accumCountSel,
  // conversion in
  input  wire csa_pkg::csa_conv_s      conv,
  // averaged result out
  output logic                         resValid,
  output logic [csa_pkg::CSA_DW-1:0]   resData
);
  import csa_pkg::*;

  logic [CSA_SUMW-1:0] sum, next_sum;
  logic [6:0]          cnt, next_cnt;
  logic                next_resValid;
  logic [CSA_DW-1:0]   next_resData;
  logic [CSA_SUMW-1:0] total;
  logic [2:0]          sh;

  // -------------------------------------------------------------
  // accumulate and divide
  // -------------------------------------------------------------
  // division by a power of two is a plain shift, no divider needed
  always_comb begin
    sh            = csa_shift(accumCountSel);
    total         = sum + CSA_SUMW'(conv.data);
    next_sum      = sum;
    next_cnt      = cnt;
    next_resValid = 1'b0;
    next_resData  = resData;
    if (conv.valid) begin
      // reaching or passing the count closes the sequence, so a count
      // selection lowered mid-sequence cannot leave the counter spinning
      if (cnt + 7'h1 >= (7'h1 << sh)) begin
        next_resValid = 1'b1;
        next_resData  = CSA_DW'(total >> sh);
        next_sum      = '0;
        next_cnt      = '0;
      end else begin
        next_sum = total;
        next_cnt = cnt + 7'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sum      <= '0;
      cnt      <= '0;
      resValid <= 1'b0;
      resData  <= '0;
    end else begin
      sum      <= next_sum;
      cnt      <= next_cnt;
      resValid <= next_resValid;
      resData  <= next_resData;
    end
  end

  chk_single_pass: assert property (@(posedge clk_sys) disable iff (reset)
    conv.valid && accumCountSel == CSA_ACC_NONE |=> resValid && resData == $past(conv.data))
    else $error("single sample not passed through");

endmodule

// >>> hdl/csa_pkg.sv
// csa_pkg: shared constants, register map and carrier types of the
// capacitive-sense accumulate/scan block.
// assumes: a single 10 MHz system clock and an 8-bit register port.
package csa_pkg;

  // ---------------------------------------------------------------
  // data widths
  // ---------------------------------------------------------------
  localparam int CSA_DW   = 16;  // conversion and result width
  localparam int CSA_SUMW = 22;  // 16 bits plus log2(64)
  localparam int CSA_CHW  = 5;   // channel select width
  localparam int CSA_AW   = 4;   // register address width

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] CSA_CONFIG   = 4'h0;
  localparam logic [3:0] CSA_RES_HI   = 4'h1;
  localparam logic [3:0] CSA_RES_LO   = 4'h2;
  localparam logic [3:0] CSA_THR_HI   = 4'h3;
  localparam logic [3:0] CSA_THR_LO   = 4'h4;
  localparam logic [3:0] CSA_CHSEL    = 4'h5;
  localparam logic [3:0] CSA_SCAN_ST  = 4'h6;
  localparam logic [3:0] CSA_SCAN_END = 4'h7;
  localparam logic [3:0] CSA_STATUS   = 4'h8;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CSA_CFG_SCAN   = 4;  // config: auto-scan enable
  localparam int CSA_ST_DONE    = 0;  // status: conversion complete
  localparam int CSA_ST_GT      = 1;  // status: greater-than
  localparam logic [7:0] CSA_THR_RST = 8'hff;
  localparam logic [2:0] CSA_ACC_NONE = 3'h0;

  // one finished conversion from the converter
  typedef struct packed {
    logic              valid;
    logic [CSA_DW-1:0] data;
  } csa_conv_s;

  // register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [CSA_AW-1:0] addr;
    logic [7:0]        wdata;
  } csa_req_s;

  // log2 of the sample count: codes 0..5 -> 1,4,8,16,32,64
  function automatic logic [2:0] csa_shift(input logic [2:0] sel);
    case (sel)
      3'h0:    csa_shift = 3'h0;
      3'h1:    csa_shift = 3'h2;
      3'h2:    csa_shift = 3'h3;
      3'h3:    csa_shift = 3'h4;
      3'h4:    csa_shift = 3'h5;
      default: csa_shift = 3'h6;
    endcase
  endfunction

endpackage

// >>> hdl/csa_scan.sv
// csa_scan: capacitive-sense post-conversion logic with registers.
// assumes: converter delivers one-cycle conversion pulses on clk_sys
// and reads channelSelect to pick its next input.
//
// Operation
// - accumulate 1,4,8,16,32 or 64 samples
// - divide sum by count into result
// - no accumulation: flag after each conversion
// - accumulating: flag after full count only
// - strictly greater result sets flag, halts scan
// - scan without hit advances channel by one
// - past end channel reload start channel
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module csa_scan (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // register port
  input  wire csa_pkg::csa_req_s       req,
  output logic [7:0]                   rdata,
  // converter side
  input  wire csa_pkg::csa_conv_s      conv,
  output logic [csa_pkg::CSA_CHW-1:0]  channelSelect,
  // status
  output logic                         convCompleteFlag,
  output logic                         greaterThanFlag,
  output logic                         scanActive
);
  import csa_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]         capsenseConfigReg, next_capsenseConfigReg;
  logic [7:0]         thresholdHighByte, next_thresholdHighByte;
  logic [7:0]         thresholdLowByte,  next_thresholdLowByte;
  logic [CSA_CHW-1:0] scanStartChannel,  next_scanStartChannel;
  logic [CSA_CHW-1:0] scanEndChannel,    next_scanEndChannel;
  logic [CSA_CHW-1:0] next_channelSelect;
  logic [CSA_DW-1:0]  result, next_result;
  logic               next_convCompleteFlag, next_greaterThanFlag, next_scanActive;
  logic [7:0]         next_rdata;
  logic               resValid;
  logic [CSA_DW-1:0]  resData;
  logic               hit;

  // ---------------------------------------------------------------
  // accumulator
  // ---------------------------------------------------------------
  csa_accum u_accum (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .accumCountSel (capsenseConfigReg[2:0]),
    .conv          (conv),
    .resValid      (resValid),
    .resData       (resData)
  );

  // strict compare against the threshold pair
  assign hit = resData > {thresholdHighByte, thresholdLowByte};

  // ---------------------------------------------------------------
  // registers, flags and channel stepping
  // ---------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  always_comb begin
    next_capsenseConfigReg = capsenseConfigReg;
    next_thresholdHighByte = thresholdHighByte;
    next_thresholdLowByte  = thresholdLowByte;
    next_scanStartChannel  = scanStartChannel;
    next_scanEndChannel    = scanEndChannel;
    next_channelSelect     = channelSelect;
    next_result            = result;
    next_convCompleteFlag  = convCompleteFlag;
    next_greaterThanFlag   = greaterThanFlag;
    next_scanActive        = scanActive;
    next_rdata             = 8'h00;
    if (req.wr) begin
      case (req.addr)
        CSA_CONFIG: begin
          next_capsenseConfigReg = req.wdata;
          next_scanActive        = req.wdata[CSA_CFG_SCAN];
        end
        CSA_THR_HI:   next_thresholdHighByte = req.wdata;
        CSA_THR_LO:   next_thresholdLowByte  = req.wdata;
        CSA_CHSEL:    next_channelSelect     = req.wdata[CSA_CHW-1:0];
        CSA_SCAN_ST:  next_scanStartChannel  = req.wdata[CSA_CHW-1:0];
        CSA_SCAN_END: next_scanEndChannel    = req.wdata[CSA_CHW-1:0];
        CSA_STATUS: begin
          // write one to clear
          if (req.wdata[CSA_ST_DONE]) next_convCompleteFlag = 1'b0;
          if (req.wdata[CSA_ST_GT])   next_greaterThanFlag  = 1'b0;
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        CSA_CONFIG:   next_rdata = {capsenseConfigReg[7:5], scanActive,
                                    capsenseConfigReg[3:0]};
        CSA_RES_HI:   next_rdata = result[15:8];
        CSA_RES_LO:   next_rdata = result[7:0];
        CSA_THR_HI:   next_rdata = thresholdHighByte;
        CSA_THR_LO:   next_rdata = thresholdLowByte;
        CSA_CHSEL:    next_rdata = 8'(channelSelect);
        CSA_SCAN_ST:  next_rdata = 8'(scanStartChannel);
        CSA_SCAN_END: next_rdata = 8'(scanEndChannel);
        CSA_STATUS:   next_rdata = {6'h00, greaterThanFlag, convCompleteFlag};
        default:      next_rdata = 8'h00;
      endcase
    end
    if (resValid) begin
      next_result           = resData;
      next_convCompleteFlag = 1'b1;
      if (hit) begin
        next_greaterThanFlag = 1'b1;
        next_scanActive      = 1'b0;
      end else if (scanActive) begin
        if (channelSelect >= scanEndChannel)
          next_channelSelect = scanStartChannel;
        else
          next_channelSelect = channelSelect + 5'h01;
      end
    end
  end

  // registers only; without scan the channel changes only by writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      capsenseConfigReg <= '0;
      thresholdHighByte <= CSA_THR_RST;
      thresholdLowByte  <= CSA_THR_RST;
      scanStartChannel  <= '0;
      scanEndChannel    <= '0;
      channelSelect     <= '0;
      result            <= '0;
      convCompleteFlag  <= 1'b0;
      greaterThanFlag   <= 1'b0;
      scanActive        <= 1'b0;
      rdata             <= 8'h00;
    end else begin
      capsenseConfigReg <= next_capsenseConfigReg;
      thresholdHighByte <= next_thresholdHighByte;
      thresholdLowByte  <= next_thresholdLowByte;
      scanStartChannel  <= next_scanStartChannel;
      scanEndChannel    <= next_scanEndChannel;
      channelSelect     <= next_channelSelect;
      result            <= next_result;
      convCompleteFlag  <= next_convCompleteFlag;
      greaterThanFlag   <= next_greaterThanFlag;
      scanActive        <= next_scanActive;
      rdata             <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // every averaged result is stored and flagged on the next edge
  chk_flag_on_result: assert property (@(posedge clk_sys) disable iff (reset)
    resValid |=> convCompleteFlag && result == $past(resData))
    else $error("result not stored with flag");
  // a hit freezes the channel and stops the scan
  chk_gt_halts: assert property (@(posedge clk_sys) disable iff (reset)
    resValid && hit |=> greaterThanFlag && !scanActive && $stable(channelSelect))
    else $error("hit did not halt scan");
  // an equal or lower result never raises the greater-than flag
  chk_gt_strict: assert property (@(posedge clk_sys) disable iff (reset)
    resValid && !hit && !greaterThanFlag |=> !greaterThanFlag)
    else $error("gt flag without strict hit");
  chk_scan_step: assert property (@(posedge clk_sys) disable iff (reset)
    resValid && !hit && scanActive && !req.wr && channelSelect < scanEndChannel
    |=> channelSelect == $past(channelSelect) + 5'h01)
    else $error("scan did not advance");
  // only a config write can start a scan
  chk_scan_needs_cfg: assert property (@(posedge clk_sys) disable iff (reset)
    !scanActive && !(req.wr && req.addr == CSA_CONFIG) |=> !scanActive)
    else $error("scan started without config");
  chk_scan_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    resValid && !hit && scanActive && !req.wr && channelSelect >= scanEndChannel
    |=> channelSelect == $past(scanStartChannel))
    else $error("scan did not wrap");
  // a step lands at or below the end channel or back on the start channel
  chk_scan_bound: assert property (@(posedge clk_sys) disable iff (reset)
    resValid && !hit && scanActive && !req.wr
    |=> (channelSelect <= $past(scanEndChannel)) || (channelSelect == $past(scanStartChannel)))
    else $error("scan stepped past end");
  chk_no_scan_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !scanActive && !req.wr |=> $stable(channelSelect))
    else $error("channel moved without scan");
  chk_no_early: assert property (@(posedge clk_sys) disable iff (reset)
    !resValid && !req.wr && !convCompleteFlag |=> !convCompleteFlag)
    else $error("flag set without result");
  // the stored result only moves when a new average arrives
  chk_result_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !resValid |=> $stable(result))
    else $error("result changed without average");
  // read data are zero except in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !req.rd |=> rdata == 8'h00)
    else $error("read data not idle");

endmodule

// >>> testbench/tb.sv
// tb: self-checking bench for the cap-sense accumulate/scan block.
// assumes: csa_scan as top, driven on its register port and conversion pulses.
`timescale 1ns/1ps
module tb;
  import csa_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic               clk_sys     = 1'b0;
  logic               reset       = 1'b1;
  csa_req_s           req         = '0;
  csa_conv_s          conv        = '0;
  logic [7:0]         rdata;
  logic [CSA_CHW-1:0] channelSelect;
  logic               convCompleteFlag;
  logic               greaterThanFlag;
  logic               scanActive;
  int                 n_fail      = 0;
  int                 checks_done = 0;

  csa_scan uut (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .req              (req),
    .rdata            (rdata),
    .conv             (conv),
    .channelSelect    (channelSelect),
    .convCompleteFlag (convCompleteFlag),
    .greaterThanFlag  (greaterThanFlag),
    .scanActive       (scanActive)
  );

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one-cycle write strobe; a gap cycle follows so strobes never merge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1 check({8'h00, rdata}, {8'h00, exp}, what);
  endtask

  task automatic sample(input logic [15:0] d);
    @(posedge clk_sys);
    conv <= '{valid: 1'b1, data: d};
    @(posedge clk_sys);
    conv.valid <= 1'b0;
  endtask

  // results and flags land two edges after the completing sample
  task automatic settle;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog well beyond the roughly 730 cycles the tests need
  initial begin
    #(20000 * 100);
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [21:0] sum;
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] sd [4];
    logic [4:0]  sc [4];
    int          n;
    sd = '{16'h0100, 16'h0100, 16'h0100, 16'h2000};
    sc = '{5'h04, 5'h02, 5'h03, 5'h03};
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(CSA_THR_HI, 8'hff, "thr hi reset");
    rd(CSA_THR_LO, 8'hff, "thr lo reset");
    rd(4'hf, 8'h00, "unmapped read");
    check(16'(convCompleteFlag), 16'h0000, "done at reset");
    $display("test reset done");
    // every count code, codes 6 and 7 standing in for 64; channel must not move
    wr(CSA_CHSEL, 8'h09);
    for (int c = 0; c < 8; c++) begin
      n = (c == 0) ? 1 : (2 << ((c > 5) ? 5 : c));
      wr(CSA_CONFIG, c[7:0]);
      wr(CSA_STATUS, 8'h03);
      sum = '0;
      for (int i = 0; i < n; i++) begin
        d = 16'h1000 + 16'(i * 257) + 16'(c);
        sum = sum + 22'(d);
        if (i == n - 1 && n > 1) begin
          settle();
          check(16'(convCompleteFlag), 16'h0000, "done before count");
        end
        sample(d);
      end
      settle();
      e = 16'(sum / n);
      check(16'(convCompleteFlag), 16'h0001, "done after count");
      check(16'(greaterThanFlag), 16'h0000, "gt at max thr");
      check(16'(channelSelect), 16'h0009, "channel kept");
      rd(CSA_RES_HI, e[15:8], "result hi");
      rd(CSA_RES_LO, e[7:0], "result lo");
    end
    $display("test accumulate done");
    // threshold is strictly greater: equal must not set the flag
    wr(CSA_CONFIG, 8'h00);
    wr(CSA_THR_HI, 8'h12);
    wr(CSA_THR_LO, 8'h34);
    wr(CSA_STATUS, 8'h03);
    sample(16'h1234);
    settle();
    check(16'(greaterThanFlag), 16'h0000, "equal not gt");
    sample(16'h1235);
    settle();
    check(16'(greaterThanFlag), 16'h0001, "above thr gt");
    rd(CSA_STATUS, 8'h03, "status flags");
    wr(CSA_STATUS, 8'h03);
    rd(CSA_STATUS, 8'h00, "status cleared");
    // a clear landing with a new result loses: the hardware set wins
    sample(16'h0010);
    req <= '{wr: 1'b1, rd: 1'b0, addr: CSA_STATUS, wdata: 8'h03};
    @(posedge clk_sys);
    req <= '0;
    #1 check(16'(convCompleteFlag), 16'h0001, "set beats clear");
    $display("test threshold done");
    // scan 2..4 from 3 with count 4: step, wrap, then halt on a hit
    wr(CSA_SCAN_ST, 8'h02);
    wr(CSA_SCAN_END, 8'h04);
    wr(CSA_CHSEL, 8'h03);
    wr(CSA_CONFIG, 8'h11);
    #1 check(16'(scanActive), 16'h0001, "scan running");
    for (int s = 0; s < 4; s++) begin
      repeat (4) sample(sd[s]);
      settle();
      check(16'(channelSelect), 16'(sc[s]), "scan channel");
    end
    check(16'(scanActive), 16'h0000, "scan halted");
    rd(CSA_CONFIG, 8'h01, "config after hit");
    repeat (4) sample(16'h0100);
    settle();
    check(16'(channelSelect), 16'h0003, "channel after halt");
    $display("test scan done");
    // reset in mid-sequence: outputs clear and a partial sum is dropped
    wr(CSA_CONFIG, 8'h01);
    repeat (2) sample(16'h0100);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1 check(16'(channelSelect), 16'h0000, "channel after reset");
    check(16'(greaterThanFlag), 16'h0000, "gt after reset");
    check(16'(convCompleteFlag), 16'h0000, "done after reset");
    check(16'(scanActive), 16'h0000, "scan after reset");
    rd(CSA_THR_HI, 8'hff, "thr hi after reset");
    wr(CSA_CONFIG, 8'h01);
    repeat (4) sample(16'h0400);
    settle();
    rd(CSA_RES_HI, 8'h04, "fresh sum hi");
    rd(CSA_RES_LO, 8'h00, "fresh sum lo");
    $display("test reset again done");
    stop_test();
  end
endmodule
